// File: hdl/acr_pkg.sv
package acr_pkg;
  // Register space geometry.
  localparam int NREG = 20;
  localparam int AW = 13;
  localparam int DW = 8;
  localparam logic [12:0] ADDR_PORT  = 13'h0000;
  localparam logic [12:0] ADDR_ID    = 13'h0001;
  localparam logic [12:0] ADDR_GRADE = 13'h0002;
  localparam logic [12:0] ADDR_FN_LO = 13'h0008;
  localparam logic [12:0] ADDR_FN_HI = 13'h0018;
  localparam logic [12:0] ADDR_CLOCK = 13'h0009;
  localparam logic [12:0] ADDR_PHASE = 13'h0014;
  localparam logic [12:0] ADDR_XFER  = 13'h00FF;
  // Storage index of each mapped byte.
  localparam int IDX_PORT  = 0;
  localparam int IDX_ID    = 1;
  localparam int IDX_GRADE = 2;
  localparam int IDX_FN0   = 3;
  localparam int IDX_CLOCK = IDX_FN0 + 1;
  localparam int IDX_PHASE = IDX_FN0 + 12;
  // Reset values.
  localparam logic [7:0] PORT_RST  = 8'h18;
  localparam logic [7:0] CLOCK_RST = 8'h01;
  localparam logic [7:0] PHASE_RST = 8'h03;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // Field positions.
  localparam int BIT_LSB_HI  = 6;
  localparam int BIT_SRST_HI = 5;
  localparam int BIT_SRST_LO = 2;
  localparam int BIT_LSB_LO  = 1;
  localparam int GRADE_BIT   = 3;
  localparam int XFER_BIT    = 0;
  localparam int STAB_BIT    = 0;
  // Serial frame layout.
  localparam int INS_RW = 15;
  localparam int INS_LEN_HI = 14;
  localparam int INS_LEN_LO = 13;
  localparam logic [3:0] INS_LAST  = 4'hF;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  // Core cycles waited after reset release before the strap is caught.
  localparam logic [1:0] SETTLE = 2'h2;

  typedef enum logic [1:0] {ACR_INSTR, ACR_DATA, ACR_DONE} acr_phase_type;

  // Maps a serial address to its storage index, or -1 when unmapped.
  function automatic int acr_index(input logic [12:0] a);
    if (a <= ADDR_GRADE) return int'(a);
    if (a >= ADDR_FN_LO && a <= ADDR_FN_HI) return IDX_FN0 + int'(a - ADDR_FN_LO);
    return -1;
  endfunction

  // Default value of each writable byte.
  function automatic logic [7:0] acr_default(input int i);
    if (i == IDX_PORT) return PORT_RST;
    if (i == IDX_CLOCK) return CLOCK_RST;
    if (i == IDX_PHASE) return PHASE_RST;
    return ZERO_BYTE;
  endfunction
endpackage

// File: hdl/acr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface acr_link_if;
  import acr_pkg::*;
  logic                 wr_tog;
  logic [AW-1:0]        wr_addr;
  logic [DW-1:0]        wr_data;
  logic [NREG*DW-1:0]   bank;
  logic                 en;
  modport link (output wr_tog, wr_addr, wr_data, input bank, en);
  modport core (input wr_tog, wr_addr, wr_data, output bank, en);
endinterface
`default_nettype wire

// File: hdl/acr_serial_link.sv
`timescale 1ns/1ps
`default_nettype none
module acr_serial_link import acr_pkg::*; (
  input  wire logic  sclk_in,     // Serial clock, runs only inside frames.
  input  wire logic  reset_n_in,  // Power-on reset, active low.
  input  wire logic  csb_in,      // Chip select, active low.
  input  wire logic  sdio_in,     // Data pin level.
  output logic       sdio_out,    // Data pin drive value.
  output logic       sdio_oe_out, // Data pin drive enable.
  acr_link_if.link   lnk_io       // Write events out, register mirror in.
);
  logic               frame_rst_n;
  logic [NREG*DW-1:0] bank_s1_q, bank_s2_q;
  logic               en_s1_q, en_s2_q, lsb, lsb_q;
  acr_phase_type      phase_q;
  logic [3:0]         cnt_q;
  logic [15:0]        sr_q, sr_d;
  logic               rw_q, stream_q, ins_end, byte_end, wr_fire;
  logic [1:0]         left_q;
  logic [AW-1:0]      addr_q, addr_nx;
  logic [DW-1:0]      tx_q, byte_in;

  // A frame is ended by chip select rising; all frame state clears then.
  assign frame_rst_n = reset_n_in & ~csb_in;

  // Register mirror and enable cross into the serial domain.
  always_ff @(posedge sclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bank_s1_q <= '0;
      bank_s2_q <= '0;
      en_s1_q   <= 1'b0;
      en_s2_q   <= 1'b0;
    end else begin
      bank_s1_q <= lnk_io.bank;
      bank_s2_q <= bank_s1_q;
      en_s1_q   <= lnk_io.en;
      en_s2_q   <= en_s1_q;
    end
  end

  // Readback byte for an address; unmapped addresses read zero.
  function automatic logic [DW-1:0] rd_byte(input logic [AW-1:0] a);
    int idx;
    idx = acr_index(a);
    if (idx < 0) return ZERO_BYTE;
    return bank_s2_q[idx*DW +: DW];
  endfunction

  // Bit order and address direction follow the locally tracked LSB-first bit.
  always_comb begin
    lsb      = lsb_q;
    sr_d     = lsb ? {sdio_in, sr_q[15:1]} : {sr_q[14:0], sdio_in};
    byte_in  = lsb ? sr_d[15:8] : sr_d[7:0];
    ins_end  = (phase_q == ACR_INSTR) && (cnt_q == INS_LAST);
    byte_end = (phase_q == ACR_DATA) && (cnt_q == BYTE_LAST);
    wr_fire  = byte_end && !rw_q;
    addr_nx  = lsb ? addr_q + 13'h0001 : addr_q - 13'h0001;
  end

  // Frame sequencer: 16 instruction bits, then 8-bit bytes.
  always_ff @(posedge sclk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      phase_q  <= ACR_INSTR;
      cnt_q    <= 4'h0;
      sr_q     <= 16'h0000;
      rw_q     <= 1'b0;
      stream_q <= 1'b0;
      left_q   <= 2'h0;
      addr_q   <= 13'h0000;
      tx_q     <= 8'h00;
    end else if (phase_q != ACR_DONE) begin
      sr_q  <= sr_d;
      cnt_q <= cnt_q + 4'h1;
      if (ins_end) begin
        phase_q  <= ACR_DATA;
        cnt_q    <= 4'h0;
        rw_q     <= sr_d[INS_RW];
        stream_q <= sr_d[INS_LEN_HI] & sr_d[INS_LEN_LO];
        left_q   <= {sr_d[INS_LEN_HI], sr_d[INS_LEN_LO]};
        addr_q   <= sr_d[AW-1:0];
        tx_q     <= rd_byte(sr_d[AW-1:0]);
      end else if (byte_end) begin
        cnt_q  <= 4'h0;
        addr_q <= addr_nx;
        tx_q   <= rd_byte(addr_nx);
        if (!stream_q) begin
          if (left_q == 2'h0) phase_q <= ACR_DONE;
          else left_q <= left_q - 2'h1;
        end
      end
    end
  end

  // Completed write bytes are handed over by a toggle with stable data.
  always_ff @(posedge sclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lnk_io.wr_tog  <= 1'b0;
      lnk_io.wr_addr <= 13'h0000;
      lnk_io.wr_data <= 8'h00;
    end else if (wr_fire) begin
      lnk_io.wr_tog  <= ~lnk_io.wr_tog;
      lnk_io.wr_addr <= addr_q;
      lnk_io.wr_data <= byte_in;
    end
  end

  // Bit order is taken from completed port writes here, since the mirror
  // needs two serial edges and would decode the next frame's first bits wrongly.
  always_ff @(posedge sclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lsb_q <= 1'b0;
    end else if (wr_fire && en_s2_q && addr_q == ADDR_PORT) begin
      lsb_q <= ~(byte_in[BIT_SRST_HI] | byte_in[BIT_SRST_LO])
               & (byte_in[BIT_LSB_HI] | byte_in[BIT_LSB_LO]);
    end
  end

  // Readback is driven on falling edges, only in the data phase of a read.
  always_ff @(negedge sclk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sdio_oe_out <= 1'b0;
      sdio_out    <= 1'b0;
    end else begin
      sdio_oe_out <= (phase_q == ACR_DATA) && rw_q && en_s2_q;
      sdio_out    <= lsb ? tx_q[cnt_q[2:0]] : tx_q[~cnt_q[2:0]];
    end
  end

  chk_oe_read_only: assert property (@(posedge sclk_in) disable iff (!frame_rst_n)
    sdio_oe_out |-> rw_q && phase_q == ACR_DATA)
    else $error("data pin driven outside a read data phase");
  chk_instr_sixteen: assert property (@(posedge sclk_in) disable iff (!frame_rst_n)
    ins_end |=> phase_q == ACR_DATA && cnt_q == 4'h0)
    else $error("instruction phase did not end after sixteen bits");
  cov_read_frame: cover property (@(posedge sclk_in) disable iff (!frame_rst_n)
    byte_end && rw_q);
endmodule
`default_nettype wire

// File: hdl/acr_config_regs.sv
// What this block does
// - Clock and select are inputs; data pin is input on writes, driven on reads.
// - Select high at power up disables the serial configuration interface.
// - In strap mode pin levels statically set data format and duty stabilizer.
// - Map holds chip config 0x00-0x02, transfer at 0xFF, functions 0x08-0x18.
// - Asserting reset loads every configuration register with its default.
// - Default output phase places the data clock edge 90 degrees from nominal.
// - Function bytes store bits as written; port bits 4:3 always read one and bits 6 and 1 set together.
// - A frame opens with a 16-bit instruction giving direction and byte count.
// - Lowering select after a strapped power up loses strap functions for good.
`timescale 1ns/1ps
`default_nettype none
module acr_config_regs import acr_pkg::*; #(
  parameter logic [7:0] DEVICE_ID      = 8'h5A, // Arbitrary identity value.
  parameter logic       SPEED_CHILD_ID = 1'b0   // Speed grade child bit.
) (
  input  wire logic  ref_clk_in,                   // Core clock, 200 MHz.
  input  wire logic  reset_n_in,                   // Asynchronous reset, active low.
  input  wire logic  clk_en_in,                    // Freezes core state while low.
  input  wire logic  csb_in,                       // Chip select pin, active low.
  input  wire logic  sclk_in,                      // Serial clock pin.
  input  wire logic  sdio_in,                      // Data pin input level.
  output logic       sdio_out,                     // Data pin drive value.
  output logic       sdio_oe_out,                  // Data pin drive enable.
  output logic       serial_enabled_out,           // Serial interface is live.
  output logic       duty_cycle_stabilizer_out,    // Duty cycle stabilizer enable.
  output logic       data_format_select_strap_out, // Output data format select.
  output logic [3:0] data_output_clock_phase_out   // Data output clock phase code.
);
  acr_link_if  lnk ();
  logic [2:0]    pin_s1_q, pin_s2_q;
  logic          csb_s, sclk_s, sdio_s;
  logic [1:0]    settle_q;
  logic          cap_done_q, strap_q, serial_en;
  logic          tog_s1_q, tog_s2_q, tog_s3_q, wr_evt, wr_ok;
  logic          srst, xfer, port_lsb;
  logic [AW-1:0] wa;
  logic [DW-1:0] wd;
  int            widx;
  logic [DW-1:0] regs_q [NREG];
  logic [DW-1:0] act_clock_q, act_phase_q;
  logic          stab_q, fmt_q;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  // Serial front end on the serial clock.
  acr_serial_link u_link (
    .sclk_in     (sclk_in),
    .reset_n_in  (reset_n_in),
    .csb_in      (csb_in),
    .sdio_in     (sdio_in),
    .sdio_out    (sdio_out),
    .sdio_oe_out (sdio_oe_out),
    .lnk_io      (lnk)
  );

  // Pin levels pass two flip-flops before the core reads them.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_s1_q <= 3'h4;
      pin_s2_q <= 3'h4;
    end else if (clk_en_in) begin
      pin_s1_q <= {csb_in, sclk_in, sdio_in};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign csb_s  = pin_s2_q[2];
  assign sclk_s = pin_s2_q[1];
  assign sdio_s = pin_s2_q[0];

  // Strap is caught once after reset release; select going low ends it for good.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      settle_q   <= 2'h0;
      cap_done_q <= 1'b0;
      strap_q    <= 1'b0;
    end else if (clk_en_in) begin
      if (!cap_done_q) begin
        settle_q <= settle_q + 2'h1;
        if (settle_q == SETTLE) begin
          cap_done_q <= 1'b1;
          strap_q    <= csb_s;
        end
      end else if (strap_q && !csb_s) begin
        strap_q <= 1'b0;
      end
    end
  end

  // The serial interface stays disabled while the strap holds.
  assign serial_en          = cap_done_q && !strap_q;
  assign serial_enabled_out = serial_en;
  assign lnk.en             = serial_en;

  // Write events arrive as a toggle; the edge detector reads the second stage.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end else if (clk_en_in) begin
      tog_s1_q <= lnk.wr_tog;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  // Decode of a completed write byte.
  always_comb begin
    wr_evt   = tog_s2_q ^ tog_s3_q;
    wa       = lnk.wr_addr;
    wd       = lnk.wr_data;
    wr_ok    = wr_evt && serial_en;
    widx     = acr_index(wa);
    srst     = wr_ok && wa == ADDR_PORT && (wd[BIT_SRST_HI] | wd[BIT_SRST_LO]);
    xfer     = wr_ok && wa == ADDR_XFER && wd[XFER_BIT];
    port_lsb = wd[BIT_LSB_HI] | wd[BIT_LSB_LO];
  end

  // Default per storage index, with identity bytes fixed.
  function automatic logic [DW-1:0] reg_default(input int i);
    if (i == IDX_ID) return DEVICE_ID;
    if (i == IDX_GRADE) return {4'h0, SPEED_CHILD_ID, 3'h0};
    return acr_default(i);
  endfunction

  // Register storage; soft reset self-clears by reloading all defaults.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= reg_default(i);
      end
    end else if (clk_en_in) begin
      if (srst) begin
        for (int i = 0; i < NREG; i++) begin
          regs_q[i] <= reg_default(i);
        end
      end else if (wr_ok && wa == ADDR_PORT) begin
        regs_q[IDX_PORT] <= {1'b0, port_lsb, 1'b0, 2'h3, 1'b0, port_lsb, 1'b0};
      end else if (wr_ok && widx >= IDX_FN0) begin
        regs_q[widx] <= wd;
      end
    end
  end

  // Function bytes take effect only on a transfer write.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      act_clock_q <= CLOCK_RST;
      act_phase_q <= PHASE_RST;
    end else if (clk_en_in) begin
      if (srst) begin
        act_clock_q <= CLOCK_RST;
        act_phase_q <= PHASE_RST;
      end else if (xfer) begin
        act_clock_q <= regs_q[IDX_CLOCK];
        act_phase_q <= regs_q[IDX_PHASE];
      end
    end
  end

  // Strap mode reads pin levels; otherwise the clock register steers the stabilizer and the format stays low.
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stab_q <= CLOCK_RST[STAB_BIT];
      fmt_q  <= 1'b0;
    end else if (clk_en_in) begin
      stab_q <= strap_q ? sdio_s : act_clock_q[STAB_BIT];
      fmt_q  <= strap_q ? sclk_s : 1'b0;
    end
  end

  assign duty_cycle_stabilizer_out    = stab_q;
  assign data_format_select_strap_out = fmt_q;
  assign data_output_clock_phase_out  = act_phase_q[3:0];

  // Every stored byte is mirrored toward the serial domain for readback.
  for (genvar g = 0; g < NREG; g++) begin : g_bank
    assign lnk.bank[g*DW +: DW] = regs_q[g];
  end

  chk_port_fixed_bits: assert property (
    regs_q[IDX_PORT][4:3] == 2'h3 && regs_q[IDX_PORT][6] == regs_q[IDX_PORT][1])
    else $error("port configuration fixed or mirrored bits wrong");
  chk_soft_reset_defaults: assert property (
    clk_en_in && srst |=> regs_q[IDX_PORT] == PORT_RST && regs_q[IDX_CLOCK] == CLOCK_RST)
    else $error("soft reset did not reload defaults");
  chk_phase_after_srst: assert property (
    clk_en_in && srst |=> data_output_clock_phase_out == PHASE_RST[3:0])
    else $error("output clock phase not at default after soft reset");
  chk_fn_write_lands: assert property (
    clk_en_in && wr_ok && !srst && wa == ADDR_CLOCK |=> regs_q[IDX_CLOCK] == $past(wd))
    else $error("function byte write was not stored");
  chk_id_read_only: assert property (
    clk_en_in && wr_ok && wa == ADDR_ID && !srst |=> $stable(regs_q[IDX_ID]))
    else $error("identity byte changed by a write");
  chk_strap_blocks_write: assert property (
    strap_q && wr_evt |=> $stable(regs_q[IDX_CLOCK]) && $stable(regs_q[IDX_PORT]))
    else $error("write accepted while strapped");
  chk_strap_stab_level: assert property (
    clk_en_in && strap_q |=> duty_cycle_stabilizer_out == $past(sdio_s))
    else $error("strap duty stabilizer does not follow data pin");
  chk_strap_lost_for_good: assert property (
    cap_done_q && !strap_q |=> !strap_q)
    else $error("strap mode came back without power cycle");
  cov_strap_then_serial: cover property (strap_q ##1 !strap_q);
  cov_transfer: cover property (clk_en_in && xfer);
  cov_soft_reset: cover property (clk_en_in && srst);
endmodule
`default_nettype wire

// File: verification/acr_spi_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module acr_spi_ctl (
  output logic      csb_out,   // Chip select, active low.
  output logic      sclk_out,  // Serial clock, still between frames.
  output logic      sdio_out,  // Controller drive level on the data wire.
  input  wire logic sdio_in,   // Resolved data wire level.
  input  wire logic dut_oe_in  // Device drive enable seen on the wire.
);
  localparam realtime HALF = 62.5;
  logic lsb_q  = 1'b0; // Bit order used for whole frames.
  int   oe_bad = 0;    // Rising edges where the device drive enable differed from the read data phase.

  // The controller idles with select high and the clock parked low.
  initial begin
    csb_out  = 1'b1;
    sclk_out = 1'b0;
    sdio_out = 1'b0;
  end

  // Sets the three pins as static levels, as a strapped board would.
  task automatic pins(input logic c, input logic s, input logic d);
    csb_out  = c;
    sclk_out = s;
    sdio_out = d;
  endtask

  // Sends one frame: instruction, then n bytes written or captured.
  task automatic frame(input logic rd, input logic [1:0] w, input logic [12:0] a,
                       input int n, input logic [7:0] wd [4], output logic [7:0] got [4]);
    logic [15:0] ins;
    int          i;
    int          b;
    int          k;
    ins     = {rd, w, a};
    csb_out = 1'b0;
    #(HALF);
    for (i = 0; i < 16 + 8 * n; i++) begin
      b = (i < 16) ? i : (i - 16) % 8;
      k = lsb_q ? b : ((i < 16) ? 15 : 7) - b;
      // A released wire shows a changing pattern, never the last bit.
      if (i < 16) sdio_out = ins[k];
      else if (!rd) sdio_out = wd[(i - 16) / 8][k];
      else sdio_out = ~sdio_out;
      #(HALF) sclk_out = 1'b1;
      if (dut_oe_in !== (rd && i >= 16)) oe_bad++;
      if (rd && i >= 16) got[(i - 16) / 8][k] = sdio_in;
      #(HALF) sclk_out = 1'b0;
    end
    #(HALF) csb_out = 1'b1;
    sdio_out = ~sdio_out;
    #(2 * HALF);
  endtask
endmodule
`default_nettype wire

// File: verification/adc_serial_config_register_map_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_serial_config_register_map_bench;
  import acr_pkg::*;
  logic       ref_clk_in;
  logic       reset_n_in;
  logic       clk_en_in;
  wire logic  csb;
  wire logic  sclk;
  wire logic  ctl_d;
  wire logic  sdio_w;
  logic       dut_d;
  logic       dut_oe;
  logic       ser_en;
  logic       stab;
  logic       fmt;
  logic [3:0] phase;
  logic [7:0] wd [4];
  logic [7:0] got [4];
  int         fails      = 0;
  int         num_checks = 0;

  // The data wire follows whichever party has its driver enabled.
  assign sdio_w = dut_oe ? dut_d : ctl_d;

  // Core clock at 200 MHz.
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  acr_config_regs #(.DEVICE_ID(8'hC3), .SPEED_CHILD_ID(1'b1)) u_dut (
    .ref_clk_in                   (ref_clk_in),
    .reset_n_in                   (reset_n_in),
    .clk_en_in                    (clk_en_in),
    .csb_in                       (csb),
    .sclk_in                      (sclk),
    .sdio_in                      (sdio_w),
    .sdio_out                     (dut_d),
    .sdio_oe_out                  (dut_oe),
    .serial_enabled_out           (ser_en),
    .duty_cycle_stabilizer_out    (stab),
    .data_format_select_strap_out (fmt),
    .data_output_clock_phase_out  (phase)
  );

  acr_spi_ctl u_ctl (
    .csb_out   (csb),
    .sclk_out  (sclk),
    .sdio_out  (ctl_d),
    .sdio_in   (sdio_w),
    .dut_oe_in (dut_oe)
  );

  // Compares one seen value with its expectation.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Single byte write frame.
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    wd[0] = d;
    u_ctl.frame(1'b0, 2'b00, a, 1, wd, got);
  endtask

  // Read frame of n bytes with word length code w.
  task automatic rd(input logic [12:0] a, input logic [1:0] w, input int n);
    u_ctl.frame(1'b1, w, a, n, wd, got);
  endtask

  // Power-on reset with the given static pin levels held throughout.
  task automatic do_reset(input logic c, input logic s, input logic d);
    @(negedge ref_clk_in);
    reset_n_in = 1'b0;
    u_ctl.pins(c, s, d);
    repeat (3) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    repeat (10) @(negedge ref_clk_in);
  endtask

  // Cuts a hang short.
  initial begin
    #300000;
    fails++;
    results();
  end

  // Main sequence.
  initial begin
    reset_n_in = 1'b0;
    clk_en_in  = 1'b1;
    do_reset(1'b0, 1'b0, 1'b0);
    check(ser_en, 8'h01);
    check(fmt, 8'h00);
    check(stab, 8'h01);
    check(phase, 8'h03);
    u_ctl.pins(1'b1, 1'b0, 1'b0);
    #1.3;
    // Every word length code, reading down from the grade byte.
    for (int w = 0; w < 4; w++) begin
      rd(ADDR_GRADE, 2'(w), (w == 3) ? 3 : w + 1);
      check(got[0], 8'h08);
      if (w > 0) check(got[1], 8'hC3);
      if (w > 1) check(got[2], PORT_RST);
    end
    // Read-only, open and transfer places.
    wr(ADDR_ID, 8'h00);
    rd(ADDR_ID, 2'b00, 1);
    check(got[0], 8'hC3);
    rd(13'h0013, 2'b00, 1);
    check(got[0], 8'h00);
    rd(13'h0003, 2'b00, 1);
    check(got[0], 8'h00);
    rd(ADDR_XFER, 2'b00, 1);
    check(got[0], 8'h00);
    // Shadow writes stay hidden until the transfer bit is set.
    wr(ADDR_CLOCK, 8'h00);
    wr(ADDR_PHASE, 8'h05);
    check(stab, 8'h01);
    check(phase, 8'h03);
    rd(ADDR_PHASE, 2'b00, 1);
    check(got[0], 8'h05);
    @(negedge ref_clk_in);
    clk_en_in = 1'b0;
    wr(ADDR_XFER, 8'h01);
    check(phase, 8'h03);
    @(negedge ref_clk_in);
    clk_en_in = 1'b1;
    repeat (10) @(negedge ref_clk_in);
    check(stab, 8'h00);
    check(phase, 8'h05);
    // Soft reset through both mirrored nibbles.
    wr(ADDR_PORT, 8'h3C);
    check(phase, 8'h03);
    check(stab, 8'h01);
    rd(ADDR_PHASE, 2'b00, 1);
    check(got[0], PHASE_RST);
    // Least significant bit first, address counting up.
    wr(ADDR_PORT, 8'h5A);
    u_ctl.lsb_q = 1'b1;
    rd(ADDR_PORT, 2'b01, 2);
    check(got[0], 8'h5A);
    check(got[1], 8'hC3);
    wr(ADDR_PORT, 8'h3C);
    u_ctl.lsb_q = 1'b0;
    rd(ADDR_PORT, 2'b00, 1);
    check(got[0], PORT_RST);
    check(8'(u_ctl.oe_bad), 8'h00);
    // Strapped power up, then select lowered.
    do_reset(1'b1, 1'b1, 1'b0);
    check(ser_en, 8'h00);
    check(fmt, 8'h01);
    check(stab, 8'h00);
    u_ctl.pins(1'b1, 1'b1, 1'b1);
    repeat (10) @(negedge ref_clk_in);
    check(stab, 8'h01);
    u_ctl.pins(1'b0, 1'b1, 1'b0);
    repeat (10) @(negedge ref_clk_in);
    check(fmt, 8'h00);
    check(stab, 8'h01);
    check(ser_en, 8'h01);
    results();
  end
endmodule
`default_nettype wire
